//--- hdl/rwdt_core.sv
/*
 * runaway watchdog: 22-stage counter on a half-rate tick, tap select, keyed
 * command register, alarm pin, nmi request, optional internal reset pulse, apb slave.
 * assumes standby_idle/standby_stop come from the same pclk domain.
 */
// The register addresses and the APB register port were left to the implementer.
// Overview of operation
// - twenty-two stage binary counter advanced at half the oscillator rate
// - four timeout taps: 2^16, 2^18, 2^20, 2^22 oscillator periods
// - timeout select resets to 00, the shortest timeout
// - tap overflow raises the nmi and drives the alarm pin low
// - alarm pin stays low until software writes clear code 4EH, or with internal reset link set until the chip reset
// - clear code 4EH zeroes the counter, counting resumes from zero
// - with internal reset link set, overflow pulses reset and releases watchdog
// - internal reset link bit resets to 0
// - enable bit resets to 1, counting starts at reset release
// - disable needs enable bit cleared first, then code B1H
// - setting enable bit alone re-enables a disabled watchdog
// - counter counts again immediately after reset release
// - counter halts in idle or stop standby modes
// - counter keeps counting while the external bus is released
`timescale 1ns/1ns
module rwdt_core
	import rwdt_pkg::*;
#(
	parameter int PULSE_CYC = RWDT_PULSE_CYC
) (
	input  wire logic        pclk,                // bus and watchdog clock
	input  wire logic        presetn,             // async reset, active low
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb access phase
	input  wire logic        pwrite,              // apb direction
	input  wire logic [11:0] paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	output logic      [31:0] prdata,              // apb read data
	output logic             pready,              // apb ready
	output logic             pslverr,             // apb error
	input  wire logic        standby_idle,        // cpu in idle standby
	input  wire logic        standby_stop,        // cpu in stop standby
	input  wire logic        bus_released,        // external bus granted away
	output logic             runaway_alarm_out_n, // alarm pin, active low
	output logic             runaway_interrupt,   // nmi request, one-cycle pulse
	output logic             wdt_reset_req,       // internal chip reset request
	output logic             irq                  // status interrupt level
);
	////////////////////////////////////////////////////////////////////////////////
	logic [RWDT_CNT_W-1:0] cnt_ff;
	logic                  tick_ff;
	logic [1:0]            timeout_select_ff;
	logic                  counter_enable_bit_ff;
	logic                  internal_reset_link_ff;
	logic                  disabled_ff;
	logic                  alarm_ff;
	logic                  nmi_ff;
	rwdt_state_t           state_ff;
	logic [RWDT_PULSE_W-1:0] pulse_ff;
	logic [RWDT_IRQ_W-1:0] stat_ff;
	logic [RWDT_IRQ_W-1:0] ien_ff;
	logic [31:0]           nxt_prdata;
	logic                  wr_acc;
	logic                  rd_acc;
	logic                  cmd_clear;
	logic                  cmd_dis;
	logic                  halted;
	logic                  tap_bit;
	logic                  overflow;
	logic                  mapped;
	logic [RWDT_IRQ_W-1:0] ev;

	assign wr_acc    = psel && penable && pwrite;
	assign rd_acc    = psel && penable && !pwrite;
	assign cmd_clear = wr_acc && paddr == RWDT_CMD_OFF && pwdata[7:0] == RWDT_CLEAR_CODE;
	assign cmd_dis   = wr_acc && paddr == RWDT_CMD_OFF && pwdata[7:0] == RWDT_DIS_CODE;
	assign halted    = standby_idle || standby_stop || disabled_ff;
	assign pready    = 1'b1;
	assign mapped    = paddr == RWDT_MODE_OFF || paddr == RWDT_CMD_OFF ||
		paddr == RWDT_STAT_OFF || paddr == RWDT_IEN_OFF ||
		paddr == RWDT_ICLR_OFF || paddr == RWDT_CNT_OFF;
	assign pslverr   = psel && penable && !mapped;

	// counter stage n toggles at fc/2^(n+2); tap 2^k/fc is the carry out of stage k-2
	always_comb begin
		case (timeout_select_ff)
			2'b00:   tap_bit = &cnt_ff[14:0];
			2'b01:   tap_bit = &cnt_ff[16:0];
			2'b10:   tap_bit = &cnt_ff[18:0];
			2'b11:   tap_bit = &cnt_ff[20:0];
			default: tap_bit = 1'b0;
		endcase
	end
	assign overflow = tap_bit && tick_ff && !halted && !cmd_clear;

	////////////////////////////////////////////////////////////////////////////////
	// half-rate tick and the counter; bus release does not gate it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_ff <= 1'b0;
		end else if (!halted) begin
			tick_ff <= !tick_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else if (cmd_clear) begin
			cnt_ff <= '0;
		end else if (tick_ff && !halted) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_select_ff      <= RWDT_SEL_RST;
			counter_enable_bit_ff  <= RWDT_EN_RST;
			internal_reset_link_ff <= RWDT_LINK_RST;
		end else if (wr_acc && paddr == RWDT_MODE_OFF) begin
			timeout_select_ff      <= pwdata[RWDT_SEL_LSB+1:RWDT_SEL_LSB];
			counter_enable_bit_ff  <= pwdata[RWDT_EN_BIT];
			internal_reset_link_ff <= pwdata[RWDT_RST_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disabled_ff <= 1'b0;
		end else if (counter_enable_bit_ff) begin
			disabled_ff <= 1'b0;
		end else if (cmd_dis) begin
			disabled_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alarm, nmi and internal reset pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= RWDT_ST_RUN;
			pulse_ff <= '0;
		end else begin
			case (state_ff)
				RWDT_ST_RUN: begin
					if (overflow && internal_reset_link_ff) begin
						state_ff <= RWDT_ST_RST;
						pulse_ff <= RWDT_PULSE_W'(PULSE_CYC - 1);
					end else if (overflow) begin
						state_ff <= RWDT_ST_ALARM;
					end
				end
				RWDT_ST_ALARM: begin
					if (cmd_clear) begin
						state_ff <= RWDT_ST_RUN;
					end
				end
				RWDT_ST_RST: begin
					if (pulse_ff != '0) begin
						pulse_ff <= pulse_ff - 1'b1;
					end
				end
				default: state_ff <= RWDT_ST_RUN;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_ff <= 1'b0;
			nmi_ff   <= 1'b0;
		end else begin
			alarm_ff <= (state_ff != RWDT_ST_RUN || overflow) &&
				!(state_ff == RWDT_ST_ALARM && cmd_clear);
			nmi_ff   <= overflow;
		end
	end

	assign runaway_alarm_out_n = !alarm_ff;
	assign runaway_interrupt   = nmi_ff;
	// alarm stays low for PULSE_CYC-1 cycles before the chip reset is requested;
	// keep PULSE_CYC within 16 to 40 pclk, i.e. 8 to 20 states
	assign wdt_reset_req       = state_ff == RWDT_ST_RST && pulse_ff == '0;

	////////////////////////////////////////////////////////////////////////////////
	// sticky status, enable, write-one clear; set beats clear
	assign ev[RWDT_EV_TMO] = overflow;
	assign ev[RWDT_EV_RST] = overflow && internal_reset_link_ff;

	generate
		for (genvar i = 0; i < RWDT_IRQ_W; i++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stat_ff[i] <= 1'b0;
				end else if (ev[i]) begin
					stat_ff[i] <= 1'b1;
				end else if (wr_acc && paddr == RWDT_ICLR_OFF && pwdata[i]) begin
					stat_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_ff <= '0;
		end else if (wr_acc && paddr == RWDT_IEN_OFF) begin
			ien_ff <= pwdata[RWDT_IRQ_W-1:0];
		end
	end

	assign irq = |(stat_ff & ien_ff);

	////////////////////////////////////////////////////////////////////////////////
	// read data, registered on the setup phase
	always_comb begin
		nxt_prdata = '0;
		case (paddr)
			RWDT_MODE_OFF: begin
				nxt_prdata[RWDT_SEL_LSB+1:RWDT_SEL_LSB] = timeout_select_ff;
				nxt_prdata[RWDT_EN_BIT]                 = counter_enable_bit_ff;
				nxt_prdata[RWDT_RST_BIT]                = internal_reset_link_ff;
			end
			RWDT_STAT_OFF: nxt_prdata[RWDT_IRQ_W-1:0] = stat_ff;
			RWDT_IEN_OFF:  nxt_prdata[RWDT_IRQ_W-1:0] = ien_ff;
			RWDT_CNT_OFF:  nxt_prdata[RWDT_CNT_W-1:0] = cnt_ff;
			default:       nxt_prdata = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= nxt_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_clear_zeroes;
		@(posedge pclk) disable iff (!presetn)
		cmd_clear |=> cnt_ff == '0;
	endproperty
	a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear code did not zero counter");

	property p_alarm_on_ovf;
		@(posedge pclk) disable iff (!presetn)
		overflow |=> !runaway_alarm_out_n && runaway_interrupt;
	endproperty
	a_alarm_on_ovf: assert property (p_alarm_on_ovf) else $error("overflow without alarm");

	property p_alarm_holds;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == RWDT_ST_ALARM && !cmd_clear) |=> !runaway_alarm_out_n;
	endproperty
	a_alarm_holds: assert property (p_alarm_holds) else $error("alarm released without clear");

	property p_halt;
		@(posedge pclk) disable iff (!presetn)
		(standby_idle || standby_stop) && !cmd_clear |=> $stable(cnt_ff);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved in standby");

	property p_sel_reset;
		@(posedge pclk) $rose(presetn) |-> timeout_select_ff == 2'b00 && counter_enable_bit_ff
			&& !internal_reset_link_ff;
	endproperty
	a_sel_reset: assert property (p_sel_reset) else $error("mode reset values wrong");

	property p_dis_needs_clear_bit;
		@(posedge pclk) disable iff (!presetn)
		$rose(disabled_ff) |-> !$past(counter_enable_bit_ff) && $past(cmd_dis);
	endproperty
	a_dis_needs_clear_bit: assert property (p_dis_needs_clear_bit) else $error("bad disable");

	property p_reenable;
		@(posedge pclk) disable iff (!presetn)
		counter_enable_bit_ff |=> !disabled_ff;
	endproperty
	a_reenable: assert property (p_reenable) else $error("enable bit did not re-enable");

	sequence s_tick_pair;
		!halted && !cmd_clear ##1 !halted && !cmd_clear;
	endsequence
	property p_counts;
		@(posedge pclk) disable iff (!presetn)
		s_tick_pair |=> cnt_ff != $past(cnt_ff, 2);
	endproperty
	a_counts: assert property (p_counts) else $error("counter stuck while running");

	sequence s_pulse_start;
		overflow && internal_reset_link_ff && state_ff == RWDT_ST_RUN;
	endsequence
	property p_rst_pulse;
		@(posedge pclk) disable iff (!presetn)
		s_pulse_start |=> (!runaway_alarm_out_n && !wdt_reset_req) [*8];
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

	property p_req_in_time;
		@(posedge pclk) disable iff (!presetn)
		s_pulse_start |-> ##[16:40] wdt_reset_req;
	endproperty
	a_req_in_time: assert property (p_req_in_time) else $error("reset request late");

	property p_req_alarm;
		@(posedge pclk) disable iff (!presetn)
		wdt_reset_req |-> !runaway_alarm_out_n;
	endproperty
	a_req_alarm: assert property (p_req_alarm) else $error("reset request without alarm");

	property p_rst_alarm;
		@(posedge pclk) disable iff (!presetn)
		state_ff == RWDT_ST_RST |-> !runaway_alarm_out_n;
	endproperty
	a_rst_alarm: assert property (p_rst_alarm) else $error("alarm high during pulse");

	property p_link_stat;
		@(posedge pclk) disable iff (!presetn)
		s_pulse_start |=> stat_ff[RWDT_EV_RST];
	endproperty
	a_link_stat: assert property (p_link_stat) else $error("reset event not flagged");

	property p_bus_counts;
		@(posedge pclk) disable iff (!presetn)
		bus_released ##0 s_tick_pair |=> cnt_ff != $past(cnt_ff, 2);
	endproperty
	a_bus_counts: assert property (p_bus_counts) else $error("counter stuck on bus release");

	property p_tick_toggles;
		@(posedge pclk) disable iff (!presetn)
		!halted |=> tick_ff != $past(tick_ff);
	endproperty
	a_tick_toggles: assert property (p_tick_toggles) else $error("half-rate tick stuck");

	property p_nmi_pulse;
		@(posedge pclk) disable iff (!presetn)
		runaway_interrupt |=> !runaway_interrupt;
	endproperty
	a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi longer than a cycle");

	property p_alarm_cause;
		@(posedge pclk) disable iff (!presetn)
		$fell(runaway_alarm_out_n) |-> $past(overflow);
	endproperty
	a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without overflow");

	property p_stat_set;
		@(posedge pclk) disable iff (!presetn)
		overflow |=> stat_ff[RWDT_EV_TMO];
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("timeout not flagged");

	property p_stat_sticky;
		@(posedge pclk) disable iff (!presetn)
		stat_ff[RWDT_EV_TMO] && !(wr_acc && paddr == RWDT_ICLR_OFF) |=> stat_ff[RWDT_EV_TMO];
	endproperty
	a_stat_sticky: assert property (p_stat_sticky) else $error("timeout flag lost");

	property p_clear_releases;
		@(posedge pclk) disable iff (!presetn)
		state_ff == RWDT_ST_ALARM && cmd_clear |=> runaway_alarm_out_n;
	endproperty
	a_clear_releases: assert property (p_clear_releases) else $error("alarm kept");

	property p_dis_halts;
		@(posedge pclk) disable iff (!presetn)
		disabled_ff && !cmd_clear |=> $stable(cnt_ff);
	endproperty
	a_dis_halts: assert property (p_dis_halts) else $error("counter moved while disabled");

	sequence s_other_code;
		wr_acc && paddr == RWDT_CMD_OFF && !cmd_clear && !cmd_dis;
	endsequence
	property p_other_code;
		@(posedge pclk) disable iff (!presetn)
		s_other_code |=> !$rose(disabled_ff) &&
			(cnt_ff == $past(cnt_ff) || cnt_ff == $past(cnt_ff) + 1'b1);
	endproperty
	a_other_code: assert property (p_other_code) else $error("other code took effect");
endmodule

//--- inc/rwdt_pkg.sv
/*
 * constants for the runaway watchdog: register map, field positions, key codes, timing.
 * assumes a 32-bit apb slave at word-aligned offsets and a 10 MHz pclk.
 */
package rwdt_pkg;
	localparam logic [11:0] RWDT_MODE_OFF   = 12'h000;
	localparam logic [11:0] RWDT_CMD_OFF    = 12'h004;
	localparam logic [11:0] RWDT_STAT_OFF   = 12'h008;
	localparam logic [11:0] RWDT_IEN_OFF    = 12'h00C;
	localparam logic [11:0] RWDT_ICLR_OFF   = 12'h010;
	localparam logic [11:0] RWDT_CNT_OFF    = 12'h014;
	localparam int          RWDT_CNT_W      = 22;
	localparam int          RWDT_SEL_LSB    = 5;
	localparam int          RWDT_EN_BIT     = 7;
	localparam int          RWDT_RST_BIT    = 1;
	localparam logic [1:0]  RWDT_SEL_RST    = 2'h0;
	localparam logic        RWDT_EN_RST     = 1'h1;
	localparam logic        RWDT_LINK_RST   = 1'h0;
	localparam logic [7:0]  RWDT_CLEAR_CODE = 8'h4E;
	localparam logic [7:0]  RWDT_DIS_CODE   = 8'hB1;
	localparam int          RWDT_CLK_NS     = 100;
	localparam int          RWDT_PULSE_NS   = 2000;
	localparam int          RWDT_PULSE_CYC  = (RWDT_PULSE_NS / RWDT_CLK_NS < 1) ? 1 :
		RWDT_PULSE_NS / RWDT_CLK_NS;
	localparam int          RWDT_PULSE_W    = 6;
	localparam int          RWDT_IRQ_W      = 2;
	localparam int          RWDT_EV_TMO     = 0;
	localparam int          RWDT_EV_RST     = 1;
	typedef enum logic [1:0] {
		RWDT_ST_RUN   = 2'b00,
		RWDT_ST_ALARM = 2'b01,
		RWDT_ST_RST   = 2'b10
	} rwdt_state_t;
endpackage

//--- verification/rwdt_sys_reset.sv
/*
 * system reset partner: merges the bench reset with the watchdog's internal reset request.
 * assumes wdt_reset_req stays high until presetn falls.
 */
`timescale 1ns/1ns
module rwdt_sys_reset (
	input  wire logic pclk,          // system clock
	input  wire logic tb_rst_n,      // bench reset, active low
	input  wire logic wdt_reset_req, // watchdog asks for chip reset
	output wire logic presetn        // chip reset, active low
);
	logic hold_ff;
	// one-cycle chip reset whenever the watchdog requests it
	always_ff @(posedge pclk or negedge tb_rst_n) begin
		if (!tb_rst_n) begin
			hold_ff <= 1'h0;
		end else begin
			hold_ff <= wdt_reset_req;
		end
	end
	assign presetn = tb_rst_n & ~hold_ff;
endmodule

//--- verification/testbench.sv
/*
 * self-checking bench for the runaway watchdog over apb.
 * assumes rwdt_core and the system reset partner beside it.
 */
`timescale 1ns/1ns
module testbench;
	import rwdt_pkg::*;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er;} rwdt_row_t;
	logic        pclk = 1'h0;
	logic        tb_rst_n = 1'h0;
	wire logic   presetn;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, runaway_alarm_out_n, runaway_interrupt, wdt_reset_req, irq;
	logic        standby_idle = 1'h0, standby_stop = 1'h0, bus_released = 1'h0;
	int          n_fail = 0;
	int          comparisons = 0;
	rwdt_row_t   rows [11] = '{
		'{1'h1, RWDT_MODE_OFF, 32'hE2, 32'h0, 1'h0}, '{1'h0, RWDT_MODE_OFF, 32'h0, 32'hE2, 1'h0},
		'{1'h1, RWDT_MODE_OFF, 32'hA0, 32'h0, 1'h0}, '{1'h0, RWDT_MODE_OFF, 32'h0, 32'hA0, 1'h0},
		'{1'h1, RWDT_MODE_OFF, 32'h80, 32'h0, 1'h0}, '{1'h0, RWDT_MODE_OFF, 32'h0, 32'h80, 1'h0},
		'{1'h0, RWDT_CMD_OFF, 32'h0, 32'h0, 1'h0}, '{1'h1, RWDT_IEN_OFF, 32'h3, 32'h0, 1'h0},
		'{1'h0, RWDT_IEN_OFF, 32'h0, 32'h3, 1'h0}, '{1'h0, 12'h018, 32'h0, 32'h0, 1'h1},
		'{1'h1, 12'h018, 32'h5, 32'h0, 1'h1}};

	always #50 pclk = ~pclk;

	rwdt_sys_reset i_rwdt_sys_reset (.pclk(pclk), .tb_rst_n(tb_rst_n),
		.wdt_reset_req(wdt_reset_req), .presetn(presetn));
	rwdt_core #(.PULSE_CYC(16)) i_rwdt_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .standby_idle(standby_idle),
		.standby_stop(standby_stop), .bus_released(bus_released),
		.runaway_alarm_out_n(runaway_alarm_out_n), .runaway_interrupt(runaway_interrupt),
		.wdt_reset_req(wdt_reset_req), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			final_report();
		end
		q = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// counter advance over exactly 20 clocks between the two read captures
	task automatic cnt_delta(output logic [31:0] dl);
		logic [31:0] q1, q2;
		logic        e;
		apb(1'h0, RWDT_CNT_OFF, 32'h0, q1, e);
		repeat (17) @(posedge pclk);
		apb(1'h0, RWDT_CNT_OFF, 32'h0, q2, e);
		dl = q2 - q1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] q, d;
		logic        er;
		int          i;
		int          j;
		logic        held;
		repeat (10) @(posedge pclk);
		tb_rst_n <= 1'h1;
		cnt_delta(d);
		check_word(d, 32'hA);
		foreach (rows[k]) begin
			apb(rows[k].w, rows[k].a, rows[k].d, q, er);
			if (!rows[k].w) check_word(q, rows[k].e);
			check_bit(er, rows[k].er);
		end
		$display("test done: register table");
		bus_released <= 1'h1;
		cnt_delta(d);
		check_word(d, 32'hA);
		bus_released <= 1'h0;
		standby_idle <= 1'h1;
		cnt_delta(d);
		check_word(d, 32'h0);
		standby_idle <= 1'h0;
		standby_stop <= 1'h1;
		cnt_delta(d);
		check_word(d, 32'h0);
		standby_stop <= 1'h0;
		$display("test done: standby and bus release");
		apb(1'h1, RWDT_CMD_OFF, 32'hB1, q, er);
		cnt_delta(d);
		check_word(d, 32'hA);
		apb(1'h1, RWDT_MODE_OFF, 32'h0, q, er);
		cnt_delta(d);
		check_word(d, 32'hA);
		apb(1'h1, RWDT_CMD_OFF, 32'hB1, q, er);
		cnt_delta(d);
		check_word(d, 32'h0);
		apb(1'h1, RWDT_MODE_OFF, 32'h80, q, er);
		cnt_delta(d);
		check_word(d, 32'hA);
		$display("test done: disable and enable");
		repeat (100) @(posedge pclk);
		apb(1'h1, RWDT_CMD_OFF, 32'h55, q, er);
		apb(1'h0, RWDT_CNT_OFF, 32'h0, q, er);
		check_bit(q > 32'h32, 1'h1);
		apb(1'h1, RWDT_CMD_OFF, 32'h4E, q, er);
		apb(1'h0, RWDT_CNT_OFF, 32'h0, q, er);
		check_bit(q < 32'h4, 1'h1);
		$display("test done: command codes");
		apb(1'h1, RWDT_IEN_OFF, 32'h0, q, er);
		apb(1'h1, RWDT_CMD_OFF, 32'h4E, q, er);
		for (i = 0; i < 70000 && runaway_interrupt !== 1'h1; i++) begin
			@(posedge pclk);
			#1;
		end
		if (i >= 70000) begin
			n_fail++;
			final_report();
		end
		check_bit(i >= 65530 && i <= 65540, 1'h1);
		check_bit(runaway_alarm_out_n, 1'h0);
		@(posedge pclk);
		#1;
		check_bit(runaway_interrupt, 1'h0);
		check_bit(irq, 1'h0);
		apb(1'h0, RWDT_STAT_OFF, 32'h0, q, er);
		check_word(q & 32'h1, 32'h1);
		apb(1'h1, RWDT_IEN_OFF, 32'h1, q, er);
		@(posedge pclk);
		#1;
		check_bit(irq, 1'h1);
		apb(1'h1, RWDT_ICLR_OFF, 32'h1, q, er);
		@(posedge pclk);
		#1;
		check_bit(irq, 1'h0);
		apb(1'h1, RWDT_CMD_OFF, 32'h0, q, er);
		@(posedge pclk);
		#1;
		check_bit(runaway_alarm_out_n, 1'h0);
		apb(1'h1, RWDT_CMD_OFF, 32'h4E, q, er);
		@(posedge pclk);
		#1;
		check_bit(runaway_alarm_out_n, 1'h1);
		$display("test done: overflow and interrupt");
		apb(1'h1, RWDT_MODE_OFF, 32'hE2, q, er);
		tb_rst_n <= 1'h0;
		repeat (3) @(posedge pclk);
		tb_rst_n <= 1'h1;
		cnt_delta(d);
		check_word(d, 32'hA);
		apb(1'h0, RWDT_MODE_OFF, 32'h0, q, er);
		check_word(q & 32'h60, 32'h0);
		check_word(q & 32'h2, 32'h0);
		check_word(q & 32'h80, 32'h80);
		$display("test done: reset in mid run");
		apb(1'h1, RWDT_MODE_OFF, 32'h82, q, er);
		apb(1'h1, RWDT_CMD_OFF, 32'h4E, q, er);
		for (i = 0; i < 70000 && runaway_interrupt !== 1'h1; i++) begin
			@(posedge pclk);
			#1;
		end
		if (i >= 70000) begin
			n_fail++;
			final_report();
		end
		held = 1'h1;
		for (j = 0; j < 100 && presetn === 1'h1; j++) begin
			held = held & (runaway_alarm_out_n === 1'h0);
			@(posedge pclk);
			#1;
		end
		check_bit(held, 1'h1);
		check_bit(j >= 16 && j <= 40, 1'h1);
		check_bit(runaway_alarm_out_n, 1'h1);
		@(posedge pclk);
		#1;
		check_bit(presetn, 1'h1);
		cnt_delta(d);
		check_word(d, 32'hA);
		apb(1'h0, RWDT_MODE_OFF, 32'h0, q, er);
		check_word(q & 32'h2, 32'h0);
		$display("test done: internal reset link");
		final_report();
	end
endmodule
